//--- rtl/uaha_top.sv
// Unary ALU and power-down instruction block with APB register access
//
// Local design decisions: the address map and the APB slave port.
`timescale 1ns/1ps
// Function
// - Complement in place inverts the addressed byte, writes it back and updates zero.
// - Complement to accumulator loads the inverted byte into the accumulator only.
// - Decimal adjust adds six to the low nibble when it exceeds nine or aux carry is set.
// - Decimal adjust adds six to the high nibble when it exceeds nine or carry is set.
// - Decimal adjust writes accumulator plus 00h, 06h, 60h or 66h to the addressed byte.
// - Decimal adjust changes only carry, set when the original high nibble exceeds nine or carry was already set.
// - Decrement in place stores the byte minus one back and updates zero.
// - Decrement to accumulator loads byte minus one into the accumulator only.
// - Power down halts execution and stops the clock while keeping all contents.
// - Power down clears the watchdog counter and its prescaler.
// - Power down sets the power-down flag, clears time-out and touches no other flag.
// - Increment in place stores the byte plus one back to the byte.
module uaha_top
(
  input  wire logic                             clock,
  input  wire logic                             rst_n,
  input  wire uaha_pkg::uaha_apb_req_type       apbReq,
  output logic      [uaha_pkg::PDATA_W-1:0]     prdata,
  output logic                                  pready,
  output logic                                  pslverr,
  input  wire logic                             watchdogTimeout,
  input  wire logic                             wakeUp,
  output logic                                  clockStop,
  output logic                                  watchdogClear
);
  import uaha_pkg::*;

  uaha_state_type    state_q;
  uaha_op_type       opcode_q;
  logic [MEM_AW-1:0] opAddr_q;
  logic [DATA_W-1:0] acc_q;
  logic              zFlag_q;
  logic              cFlag_q;
  logic              acFlag_q;
  logic              pdfFlag_q;
  logic              toFlag_q;
  logic [PDATA_W-1:0] prdata_q;
  logic              pready_q;
  logic              pslverr_q;
  logic              clockStop_q;
  logic              wdClear_q;

  uaha_alu_out_type  aluOut;
  logic [DATA_W-1:0] memRd;
  logic [DATA_W-1:0] memRdApb;
  logic              memWe;
  logic [MEM_AW-1:0] memWa;
  logic [DATA_W-1:0] memWd;
  logic              exec;
  logic              halted;
  logic              access;
  logic              apbWr;
  logic              hitCmd;
  logic              hitAcc;
  logic              hitStatus;
  logic              hitMem;
  logic [MEM_AW-1:0] apbMemIdx;
  logic [PDATA_W-1:0] statusWord;
  logic [PDATA_W-1:0] readMux;

  // ==========================================================================
  // Decode
  assign exec      = (state_q == STATE_EXEC);
  assign halted    = (state_q == STATE_HALTED);
  assign access    = apbReq.psel && apbReq.penable;
  assign apbWr     = access && apbReq.pwrite && pready_q;
  assign hitCmd    = (apbReq.paddr == ADDR_CMD);
  assign hitAcc    = (apbReq.paddr == ADDR_ACC);
  assign hitStatus = (apbReq.paddr == ADDR_STATUS);
  assign hitMem    = ((apbReq.paddr & ~MEM_WIN_MASK) == ADDR_MEM_BASE);
  assign apbMemIdx = apbReq.paddr[MEM_IDX_LSB +: MEM_AW];

  // ==========================================================================
  // Datapath
  uaha_alu u_alu
  (
    .opcode     (opcode_q),
    .operand    (memRd),
    .acc        (acc_q),
    .carryIn    (cFlag_q),
    .auxCarryIn (acFlag_q),
    .aluOut     (aluOut)
  );

  // Instruction write-back wins; software writes are refused while busy or halted
  assign memWe = exec ? aluOut.memWrite : (apbWr && hitMem && !halted);
  assign memWa = exec ? opAddr_q : apbMemIdx;
  assign memWd = exec ? aluOut.result : apbReq.pwdata[DATA_W-1:0];

  uaha_dmem #(.DEPTH(MEM_DEPTH), .AW(MEM_AW), .W(DATA_W)) u_dmem
  (
    .clock   (clock),
    .wrEn    (memWe),
    .wrAddr  (memWa),
    .wrData  (memWd),
    .rdAddrA (opAddr_q),
    .rdDataA (memRd),
    .rdAddrB (apbMemIdx),
    .rdDataB (memRdApb)
  );

  // ==========================================================================
  // Sequencer
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q  <= STATE_IDLE;
      opcode_q <= OP_NOP;
      opAddr_q <= '0;
    end
    else
    begin
      case (state_q)
        STATE_IDLE:
        begin
          if (apbWr && hitCmd)
          begin
            opcode_q <= uaha_op_type'(apbReq.pwdata[CMD_OP_LSB +: 3]);
            opAddr_q <= apbReq.pwdata[CMD_ADDR_LSB +: MEM_AW];
            state_q  <= STATE_EXEC;
          end
        end
        STATE_EXEC:
        begin
          state_q <= aluOut.halt ? STATE_HALTED : STATE_IDLE;
        end
        STATE_HALTED:
        begin
          if (wakeUp)
          begin
            state_q <= STATE_IDLE;
          end
        end
        default:
        begin
          state_q <= STATE_IDLE;
        end
      endcase
    end
  end

  // ==========================================================================
  // Accumulator
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      acc_q <= ACC_RESET;
    end
    else if (exec && aluOut.toAcc)
    begin
      acc_q <= aluOut.result;
    end
    else if (apbWr && hitAcc && !exec && !halted)
    begin
      acc_q <= apbReq.pwdata[DATA_W-1:0];
    end
  end

  // ==========================================================================
  // Flags
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      zFlag_q  <= 1'b0;
      cFlag_q  <= 1'b0;
      acFlag_q <= 1'b0;
    end
    else if (exec)
    begin
      if (aluOut.zUpd)
      begin
        zFlag_q <= aluOut.zVal;
      end
      if (aluOut.cUpd)
      begin
        cFlag_q <= aluOut.cVal;
      end
    end
    else if (apbWr && hitStatus && !halted)
    begin
      zFlag_q  <= apbReq.pwdata[ST_Z];
      cFlag_q  <= apbReq.pwdata[ST_C];
      acFlag_q <= apbReq.pwdata[ST_AC];
    end
  end

  // Watchdog time-out sets win over power-down and software clears
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pdfFlag_q <= 1'b0;
      toFlag_q  <= 1'b0;
    end
    else
    begin
      if (exec && aluOut.halt)
      begin
        pdfFlag_q <= 1'b1;
      end
      else if (apbWr && hitStatus && apbReq.pwdata[ST_PDF])
      begin
        pdfFlag_q <= 1'b0;
      end
      if (watchdogTimeout)
      begin
        toFlag_q <= 1'b1;
      end
      else if ((exec && aluOut.halt) || (apbWr && hitStatus && apbReq.pwdata[ST_TO]))
      begin
        toFlag_q <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Power-down controls
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      clockStop_q <= 1'b0;
      wdClear_q   <= 1'b0;
    end
    else
    begin
      wdClear_q <= exec && aluOut.halt;
      if (exec && aluOut.halt)
      begin
        clockStop_q <= 1'b1;
      end
      else if (halted && wakeUp)
      begin
        clockStop_q <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // APB slave, one wait state so every output stays registered
  always_comb
  begin
    statusWord          = '0;
    statusWord[ST_Z]    = zFlag_q;
    statusWord[ST_C]    = cFlag_q;
    statusWord[ST_AC]   = acFlag_q;
    statusWord[ST_PDF]  = pdfFlag_q;
    statusWord[ST_TO]   = toFlag_q;
    statusWord[ST_BUSY] = exec;
    statusWord[ST_HALT] = halted;
    readMux             = '0;
    if (hitAcc)
    begin
      readMux[DATA_W-1:0] = acc_q;
    end
    else if (hitStatus)
    begin
      readMux = statusWord;
    end
    else if (hitMem)
    begin
      readMux[DATA_W-1:0] = memRdApb;
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= '0;
    end
    else
    begin
      pready_q  <= access && !pready_q;
      pslverr_q <= access && !pready_q && !(hitCmd || hitAcc || hitStatus || hitMem);
      if (access && !pready_q && !apbReq.pwrite)
      begin
        prdata_q <= readMux;
      end
    end
  end

  assign prdata        = prdata_q;
  assign pready        = pready_q;
  assign pslverr       = pslverr_q;
  assign clockStop     = clockStop_q;
  assign watchdogClear = wdClear_q;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  sequence haltEntry;
    clockStop_q && wdClear_q && pdfFlag_q && halted;
  endsequence

  sequence haltHold;
    !wdClear_q && clockStop_q;
  endsequence

  AST_CPL_ZERO: assert property (
    exec && opcode_q == OP_COMPLEMENT_IN_PLACE |-> memWe ##1 zFlag_q == ($past(memRd) == 8'hFF))
    else $error("complement in place zero flag wrong");

  AST_COMPLEMENT_TO_ACC_ACC: assert property (
    exec && opcode_q == OP_COMPLEMENT_TO_ACC |-> !memWe ##1 acc_q == ~$past(memRd))
    else $error("complement to accumulator wrong");

  AST_DAA_LOW: assert property (
    exec && opcode_q == OP_DECIMAL_ADJUST && (acc_q[3:0] > 4'h9 || acFlag_q)
    |-> memWd[3:0] == 4'(acc_q[3:0] + 4'h6))
    else $error("decimal adjust low nibble wrong");

  AST_DAA_HIGH: assert property (
    exec && opcode_q == OP_DECIMAL_ADJUST && acc_q[3:0] <= 4'h9 && !acFlag_q
    && (acc_q[7:4] > 4'h9 || cFlag_q) |-> memWe && memWd == 8'(acc_q + 8'h60))
    else $error("decimal adjust high nibble wrong");

  AST_DAA_NONE: assert property (
    exec && opcode_q == OP_DECIMAL_ADJUST && acc_q <= 8'h99 && acc_q[3:0] <= 4'h9
    && !acFlag_q && !cFlag_q |-> memWe && memWd == acc_q)
    else $error("decimal adjust altered a valid value");

  // Carry out only comes from the high fix, which tests the original high nibble
  AST_DAA_FLAGS: assert property (
    exec && opcode_q == OP_DECIMAL_ADJUST |=> $stable(zFlag_q) && $stable(acFlag_q)
    && (cFlag_q == ($past(acc_q[7:4]) > 4'h9 || $past(cFlag_q))))
    else $error("decimal adjust flags wrong");

  AST_DEC_WRAP: assert property (
    exec && opcode_q == OP_DECREMENT_IN_PLACE |-> memWe && memWd == 8'(memRd - 8'h01)
    ##1 zFlag_q == ($past(memRd) == 8'h01))
    else $error("decrement in place wrong");

  AST_DECREMENT_TO_ACC_ACC: assert property (
    exec && opcode_q == OP_DECREMENT_TO_ACC |-> !memWe ##1 acc_q == 8'($past(memRd) - 8'h01))
    else $error("decrement to accumulator wrong");

  AST_HALT_SEQ: assert property (
    exec && opcode_q == OP_POWER_DOWN |=> haltEntry ##1 (haltHold or (!clockStop_q && !halted)))
    else $error("power down sequence wrong");

  AST_HALT_FLAGS: assert property (
    exec && opcode_q == OP_POWER_DOWN |=> pdfFlag_q && (!toFlag_q || $past(watchdogTimeout))
    && $stable(zFlag_q) && $stable(cFlag_q) && $stable(acFlag_q) && $stable(acc_q))
    else $error("power down flags wrong");

  AST_HALT_FREEZE: assert property (
    halted && !wakeUp |=> halted && clockStop_q && $stable(acc_q) && !$past(memWe))
    else $error("state changed while powered down");

  AST_INC: assert property (
    exec && opcode_q == OP_INCREMENT_IN_PLACE |-> memWe && memWd == 8'(memRd + 8'h01)
    ##1 zFlag_q == ($past(memRd) == 8'hFF) && $stable(cFlag_q) && $stable(acFlag_q))
    else $error("increment in place wrong");

endmodule // uaha_top

//--- pkg/uaha_pkg.sv
// Shared constants, opcodes and carrier types of the unary ALU and power-down block
package uaha_pkg;

  // ==========================================================================
  // Widths
  localparam int DATA_W    = 8;
  localparam int MEM_DEPTH = 16;
  localparam int MEM_AW    = 4;
  localparam int PADDR_W   = 12;
  localparam int PDATA_W   = 32;

  // ==========================================================================
  // Register map, byte addresses
  localparam logic [PADDR_W-1:0] ADDR_CMD      = 12'h000;
  localparam logic [PADDR_W-1:0] ADDR_ACC      = 12'h004;
  localparam logic [PADDR_W-1:0] ADDR_STATUS   = 12'h008;
  localparam logic [PADDR_W-1:0] ADDR_MEM_BASE = 12'h040;
  localparam logic [PADDR_W-1:0] MEM_WIN_MASK  = 12'h03C;
  localparam int                 MEM_IDX_LSB   = 2;

  // ==========================================================================
  // Field positions
  localparam int CMD_OP_LSB   = 0;
  localparam int CMD_ADDR_LSB = 8;
  localparam int ST_Z         = 0;
  localparam int ST_C         = 1;
  localparam int ST_AC        = 2;
  localparam int ST_PDF       = 3;
  localparam int ST_TO        = 4;
  localparam int ST_BUSY      = 8;
  localparam int ST_HALT      = 9;

  // ==========================================================================
  // Reset values and arithmetic constants
  localparam logic [DATA_W-1:0] ACC_RESET     = 8'h00;
  localparam logic [3:0]        BCD_DIGIT_MAX = 4'h9;
  localparam logic [DATA_W-1:0] DAA_LOW_FIX   = 8'h06;
  localparam logic [DATA_W-1:0] DAA_HIGH_FIX  = 8'h60;
  localparam logic [DATA_W-1:0] ONE_BYTE      = 8'h01;

  // ==========================================================================
  // Opcodes and states
  typedef enum logic [2:0] {
    OP_NOP                 = 3'h0,
    OP_COMPLEMENT_IN_PLACE = 3'h1,
    OP_COMPLEMENT_TO_ACC   = 3'h2,
    OP_DECIMAL_ADJUST      = 3'h3,
    OP_DECREMENT_IN_PLACE  = 3'h4,
    OP_DECREMENT_TO_ACC    = 3'h5,
    OP_INCREMENT_IN_PLACE  = 3'h6,
    OP_POWER_DOWN          = 3'h7
  } uaha_op_type;

  typedef enum logic [2:0] {
    STATE_IDLE   = 3'b001,
    STATE_EXEC   = 3'b010,
    STATE_HALTED = 3'b100
  } uaha_state_type;

  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic               psel;
    logic               penable;
    logic               pwrite;
    logic [PADDR_W-1:0] paddr;
    logic [PDATA_W-1:0] pwdata;
  } uaha_apb_req_type;

  typedef struct packed {
    logic [DATA_W-1:0] result;
    logic              memWrite;
    logic              toAcc;
    logic              zUpd;
    logic              zVal;
    logic              cUpd;
    logic              cVal;
    logic              halt;
  } uaha_alu_out_type;

endpackage

//--- rtl/uaha_alu.sv
// Combinational datapath of the unary instructions
`timescale 1ns/1ps
module uaha_alu
(
  input  wire uaha_pkg::uaha_op_type              opcode,
  input  wire logic [uaha_pkg::DATA_W-1:0]        operand,
  input  wire logic [uaha_pkg::DATA_W-1:0]        acc,
  input  wire logic                               carryIn,
  input  wire logic                               auxCarryIn,
  output uaha_pkg::uaha_alu_out_type              aluOut
);
  import uaha_pkg::*;

  logic              lowAdj;
  logic              highAdj;
  logic [DATA_W-1:0] correction;
  logic [DATA_W:0]   daaSum;

  // ==========================================================================
  // Decimal adjust correction
  assign lowAdj     = (acc[3:0] > BCD_DIGIT_MAX) || auxCarryIn;
  assign highAdj    = (acc[7:4] > BCD_DIGIT_MAX) || carryIn;
  assign correction = (lowAdj ? DAA_LOW_FIX : '0) | (highAdj ? DAA_HIGH_FIX : '0);
  assign daaSum     = {1'b0, acc} + {1'b0, correction};

  // ==========================================================================
  // Operation select
  always_comb
  begin
    aluOut = '0;
    case (opcode)
      OP_COMPLEMENT_IN_PLACE:
      begin
        aluOut.result   = ~operand;
        aluOut.memWrite = 1'b1;
        aluOut.zUpd     = 1'b1;
      end
      OP_COMPLEMENT_TO_ACC:
      begin
        aluOut.result = ~operand;
        aluOut.toAcc  = 1'b1;
        aluOut.zUpd   = 1'b1;
      end
      OP_DECIMAL_ADJUST:
      begin
        aluOut.result   = daaSum[DATA_W-1:0];
        aluOut.memWrite = 1'b1;
        aluOut.cUpd     = 1'b1;
        // Carry already set means the sum passed 99 before adjust
        aluOut.cVal     = carryIn | daaSum[DATA_W];
      end
      OP_DECREMENT_IN_PLACE:
      begin
        aluOut.result   = operand - ONE_BYTE;
        aluOut.memWrite = 1'b1;
        aluOut.zUpd     = 1'b1;
      end
      OP_DECREMENT_TO_ACC:
      begin
        aluOut.result = operand - ONE_BYTE;
        aluOut.toAcc  = 1'b1;
        aluOut.zUpd   = 1'b1;
      end
      OP_INCREMENT_IN_PLACE:
      begin
        aluOut.result   = operand + ONE_BYTE;
        aluOut.memWrite = 1'b1;
        aluOut.zUpd     = 1'b1;
      end
      OP_POWER_DOWN:
      begin
        aluOut.halt = 1'b1;
      end
      default:
      begin
        aluOut = '0;
      end
    endcase
    aluOut.zVal = (aluOut.result == '0);
  end

endmodule // uaha_alu

//--- rtl/uaha_dmem.sv
// Data memory holding the instruction operands
`timescale 1ns/1ps
module uaha_dmem
#(
  parameter int DEPTH = 16,
  parameter int AW    = 4,
  parameter int W     = 8
)
(
  input  wire logic          clock,
  input  wire logic          wrEn,
  input  wire logic [AW-1:0] wrAddr,
  input  wire logic [W-1:0]  wrData,
  input  wire logic [AW-1:0] rdAddrA,
  output logic      [W-1:0]  rdDataA,
  input  wire logic [AW-1:0] rdAddrB,
  output logic      [W-1:0]  rdDataB
);

  // ==========================================================================
  // Storage, no reset so contents survive power-down and warm reset alike
  logic [W-1:0] mem [DEPTH];

  always_ff @(posedge clock)
  begin
    if (wrEn)
    begin
      mem[wrAddr] <= wrData;
    end
  end

  assign rdDataA = mem[rdAddrA];
  assign rdDataB = mem[rdAddrB];

endmodule // uaha_dmem

//--- verification/uaha_wdog_model.sv
// Watchdog and clock generator model that faces the power-down outputs
`timescale 1ns/1ps
module uaha_wdog_model
(
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic       clockStop,
  input  wire logic       watchdogClear,
  input  wire logic       wakeReq,
  input  wire logic       timeoutReq,
  output logic            watchdogTimeout,
  output logic            wakeUp,
  output logic [7:0]      clearCount
);
  // ==========================================================================
  // Clear pulse count and wake source

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      clearCount      <= 8'h00;
      watchdogTimeout <= 1'b0;
      wakeUp          <= 1'b0;
    end
    else
    begin
      // Each clear pulse counts once, a held clear would count once per cycle
      clearCount      <= clearCount + {7'h00, watchdogClear};
      watchdogTimeout <= timeoutReq;
      // Wake only while stopped, a real source cannot wake a running core
      wakeUp          <= wakeReq & clockStop;
    end
  end
endmodule // uaha_wdog_model

//--- verification/test_unary_alu_and_halt_instr.sv
// Self-checking testbench of the unary ALU and power-down block
`timescale 1ns/1ps
module test_unary_alu_and_halt_instr;
  import uaha_pkg::*;
  // ==========================================================================
  // Signals
  logic                   clock;
  logic                   rst_n;
  uaha_apb_req_type       apbReq;
  logic [PDATA_W-1:0]     prdata;
  logic                   pready;
  logic                   pslverr;
  logic                   watchdogTimeout;
  logic                   wakeUp;
  logic                   clockStop;
  logic                   watchdogClear;
  logic                   wakeReq;
  logic                   timeoutReq;
  logic [7:0]             clearCount;
  logic [PDATA_W-1:0]     expData[$];
  logic                   expErr[$];
  int                     n_fail = 0;
  int                     n_compared = 0;
  int                     cycles = 0;

  uaha_top dut (.clock(clock), .rst_n(rst_n), .apbReq(apbReq), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .watchdogTimeout(watchdogTimeout),
    .wakeUp(wakeUp), .clockStop(clockStop), .watchdogClear(watchdogClear));

  uaha_wdog_model wdog (.clock(clock), .rst_n(rst_n), .clockStop(clockStop),
    .watchdogClear(watchdogClear), .wakeReq(wakeReq), .timeoutReq(timeoutReq),
    .watchdogTimeout(watchdogTimeout), .wakeUp(wakeUp), .clearCount(clearCount));

  initial
  begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  // ==========================================================================
  // Reporting
  task end_of_test;
    $display("Compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task check_data(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task check_bit(input logic got, input logic exp);
    n_compared++;
    if (got !== exp)
    begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Hang guard, the whole run needs under a thousand cycles
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_fail++;
      end_of_test;
    end
  end

  // ==========================================================================
  // APB master
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic err);
    expErr.push_back(err);
    @(posedge clock);
    apbReq.psel    <= 1'b1;
    apbReq.penable <= 1'b0;
    apbReq.pwrite  <= w;
    apbReq.paddr   <= a;
    apbReq.pwdata  <= d;
    @(posedge clock);
    apbReq.penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    apbReq.psel    <= 1'b0;
    apbReq.penable <= 1'b0;
  endtask

  task wr(input logic [11:0] a, input logic [31:0] d, input logic err = 1'b0);
    apb(1'b1, a, d, err);
  endtask

  task rd(input logic [11:0] a, input logic [31:0] exp, input logic err = 1'b0);
    expData.push_back(exp);
    apb(1'b0, a, 32'h0000_0000, err);
  endtask

  // Monitor takes the oldest note whenever a transfer completes
  always @(posedge clock)
  begin
    if (apbReq.psel && apbReq.penable && pready === 1'b1)
    begin
      check_bit(pslverr, expErr.pop_front());
      if (!apbReq.pwrite)
        check_data(prdata, expData.pop_front());
    end
  end

  // ==========================================================================
  // Reference of the unary operations, returns {mem, acc, ac, c, z}
  function automatic logic [18:0] refOp(input logic [2:0] op, input logic [7:0] m,
                                        input logic [7:0] a, input logic [2:0] f);
    logic [8:0] s;
    logic [7:0] r;
    logic [7:0] fix;
    fix = ((a[3:0] > 4'h9) || f[2]) ? 8'h06 : 8'h00;
    if ((a[7:4] > 4'h9) || f[1]) fix = fix | 8'h60;
    s = {1'b0, a} + {1'b0, fix};
    case (op)
      3'h1, 3'h2: r = ~m;
      3'h4, 3'h5: r = m - 8'h01;
      3'h6: r = m + 8'h01;
      default: r = s[7:0];
    endcase
    if (op == 3'h3) return {r, a, f[2], f[1] | s[8], f[0]};
    f[0] = (r == 8'h00);
    if (op == 3'h2 || op == 3'h5) return {m, r, f};
    return {r, a, f};
  endfunction

  function automatic logic [31:0] st(input logic [2:0] f, input logic power_down_flag,
                                     input logic to, input logic h);
    return 32'(f) | (32'(power_down_flag) << ST_PDF) | (32'(to) << ST_TO) | (32'(h) << ST_HALT);
  endfunction

  // ==========================================================================
  // Main sequence
  initial
  begin
    logic [7:0]  vals[4];
    logic [7:0]  accs[4];
    logic [3:0]  idx;
    logic [2:0]  f;
    logic [11:0] ma;
    logic [18:0] e;
    logic [7:0]  cnt0;
    rst_n      = 1'b0;
    apbReq     = '0;
    wakeReq    = 1'b0;
    timeoutReq = 1'b0;
    void'($urandom(32'h62C3));
    repeat (6) @(posedge clock);
    rst_n <= 1'b1;
    rd(ADDR_ACC, 32'h0000_0000);
    rd(ADDR_STATUS, 32'h0000_0000);
    rd(12'h100, 32'h0000_0000, 1'b1);
    wr(12'h100, 32'h0000_00FF, 1'b1);
    for (int op = 1; op < 7; op++)
    begin
      vals = '{8'h00, 8'hFF, 8'h01, 8'($urandom)};
      accs = '{8'h00, 8'hAA, 8'h99, 8'($urandom)};
      for (int k = 0; k < 4; k++)
      begin
        idx = 4'($urandom);
        f   = 3'($urandom);
        ma  = ADDR_MEM_BASE | {6'h00, idx, 2'b00};
        wr(ma, 32'(vals[k]));
        wr(ADDR_ACC, 32'(accs[k]));
        wr(ADDR_STATUS, 32'(f));
        wr(ADDR_CMD, 32'({idx, 5'h00, 3'(op)}));
        e = refOp(3'(op), vals[k], accs[k], f);
        rd(ma, 32'(e[18:11]));
        rd(ADDR_ACC, 32'(e[10:3]));
        rd(ADDR_STATUS, st(e[2:0], 1'b0, 1'b0, 1'b0));
      end
    end
    // Power down with time-out flag set beforehand
    ma = ADDR_MEM_BASE | 12'h00C;
    wr(ma, 32'h0000_005A);
    wr(ADDR_ACC, 32'h0000_00C3);
    wr(ADDR_STATUS, 32'h0000_0005);
    timeoutReq <= 1'b1;
    @(posedge clock);
    timeoutReq <= 1'b0;
    rd(ADDR_STATUS, st(3'h5, 1'b0, 1'b1, 1'b0));
    cnt0 = clearCount;
    wr(ADDR_CMD, 32'h0000_0307);
    repeat (4) @(posedge clock);
    check_bit(clockStop, 1'b1);
    check_data(32'(clearCount - cnt0), 32'h0000_0001);
    rd(ADDR_STATUS, st(3'h5, 1'b1, 1'b0, 1'b1));
    wr(ADDR_CMD, 32'h0000_0306);
    wr(ADDR_ACC, 32'h0000_0011);
    rd(ADDR_ACC, 32'h0000_00C3);
    rd(ma, 32'h0000_005A);
    wakeReq <= 1'b1;
    for (int i = 0; i < 20 && clockStop !== 1'b0; i++) @(posedge clock);
    wakeReq <= 1'b0;
    check_bit(clockStop, 1'b0);
    rd(ADDR_STATUS, st(3'h5, 1'b1, 1'b0, 1'b0));
    wr(ADDR_STATUS, 32'h0000_001D);
    rd(ADDR_STATUS, st(3'h5, 1'b0, 1'b0, 1'b0));
    wr(ADDR_CMD, 32'h0000_0306);
    rd(ma, 32'h0000_005B);
    rd(ADDR_STATUS, st(3'h4, 1'b0, 1'b0, 1'b0));
    // No-operation command must leave byte and flags alone
    wr(ADDR_CMD, 32'h0000_0300);
    rd(ma, 32'h0000_005B);
    rd(ADDR_STATUS, st(3'h4, 1'b0, 1'b0, 1'b0));
    end_of_test;
  end
endmodule // test_unary_alu_and_halt_instr
